//--- status_led_indicator_logic.sv
// Purpose: Drives the four front-panel lamps from driver status flags
// Assumes: Flags are synchronous to sys_clk_in; interlock release is a pulse
// Notes:
// Notes on behaviour
// (R1) Powered and idle: power lamp steady green
// (R2) Alarm: red blinks alarm-code count, green off
// (R3) Power removal active: green blinks, red off
// (R4) Information pending: both elements double blink
// (R5) Teaching or remote run: same double blink; code decodes teaching only, it has no remote-run flag
// (R6) Interlock release: both blink for set time
// (R7) Origin switch function running: both lit steady
// (R8) Simulation: green, red, both, dark repeating
// (R9) No power: module and network lamps dark
// (R10) Invalid comm settings: module lamp blinks green
// (R11) Normal operation: module lamp steady green
// (R12) Resettable alarm or address clash: blink red
// (R13) Non-resettable alarm: module lamp steady red
// (R14) Self-test: module and network lamps alternate
// (R15) Offline: network lamp dark
// (R16) Online, no connection: network lamp blinks green
// (R17) Online and connected: network lamp steady green
// (R18) Connection timeout: network lamp blinks red
// (R19) Duplicate address: network lamp steady red
// (R20) Link lamp: off, blinking on traffic, else on
// (R21) All blinking from one prescaled tick, programmable
// (R22) Power lamp priority: sim, alarm, removal, origin, interlock, info
`timescale 1ns/1ps

module status_led_indicator_logic
    import status_led_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
    input  wire logic              sys_clk_in,
    input  wire logic              reset_n_in,
    input  wire status_t           status_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic              wr_en_in,
    input  wire logic              rd_en_in,
    output lamps_t                 lamps_out,
    output logic [DATA_W-1:0]      rd_data_out
);

    // Refuse tick lengths the 16-bit prescaler cannot hold
    if (TICK_CYCLES < TICK_CYCLES_MIN || TICK_CYCLES > TICK_CYCLES_MAX) begin : g_chk
        $error("TICK_CYCLES out of range");
    end

    localparam logic [15:0] PRESCALE_RST = 16'(TICK_CYCLES);
    localparam logic [15:0] PRESCALE_MIN = 16'(TICK_CYCLES_MIN);

    state_t q;
    state_t d;

    // Combinational helpers
    logic [7:0]  half_len;
    logic        half_end;
    logic [4:0]  n_sel;
    logic        pattern_on;
    logic [15:0] wr_prescale;
    logic [15:0] ilock_next;

    // Next-state logic for the whole block
    always_comb begin
        d = q;
        d.tick = 1'b0;

        // Register writes; a tiny prescale would stall the tick, so clamp it
        wr_prescale = wr_data_in[15:0];
        if (wr_en_in) begin
            case (addr_in)
                ADDR_PRESCALE: begin
                    d.prescale = (wr_prescale < PRESCALE_MIN) ? PRESCALE_MIN
                                                              : wr_prescale;
                end
                ADDR_BLINK: begin
                    d.blink_on  = wr_data_in[BLINK_ON_LSB +: 8];
                    d.blink_off = wr_data_in[BLINK_OFF_LSB +: 8];
                end
                ADDR_ILOCK: begin
                    d.ilock_time = wr_data_in[15:0];
                end
                default: begin
                    d.prescale = q.prescale;
                end
            endcase
        end

        // Shared tick prescaler
        if (q.presc_cnt >= q.prescale - 16'h0001) begin // see (R21)
            d.presc_cnt = 16'h0000;
            d.tick      = 1'b1;
        end else begin
            d.presc_cnt = q.presc_cnt + 16'h0001;
        end

        // Blink square wave with separate on and off lengths
        half_len = q.blink ? q.blink_on : q.blink_off;
        if (half_len == 8'h00) begin
            half_len = 8'h01;
        end
        half_end = q.tick && (q.phase_cnt >= half_len - 8'h01); // see (R21)
        if (q.tick) begin
            d.phase_cnt = half_end ? 8'h00 : q.phase_cnt + 8'h01;
        end
        if (half_end) begin
            d.blink = ~q.blink;
        end

        // Group length: alarm code count, otherwise a double blink
        if (status_in.alarm) begin
            n_sel = {1'b0, status_in.alarm_count}; // see (R2)
            if (n_sel < MIN_BLINKS) begin
                n_sel = MIN_BLINKS;
            end
        end else begin
            n_sel = INFO_BLINKS; // see (R4)
        end

        // Count blinks within a group, then pause for the gap
        if (half_end && q.blink) begin
            if (q.grp >= n_sel + GROUP_GAP - 5'h01) begin
                d.grp = 5'h00;
            end else begin
                d.grp = q.grp + 5'h01;
            end
        end
        pattern_on = q.blink && (q.grp < n_sel);

        // Simulation colour sequence steps on each half period
        if (half_end) begin
            case (q.sim) // see (R8)
                SIM_GREEN: d.sim = SIM_RED;
                SIM_RED:   d.sim = SIM_BOTH;
                SIM_BOTH:  d.sim = SIM_DARK;
                SIM_DARK:  d.sim = SIM_GREEN;
                default:   d.sim = SIM_GREEN;
            endcase
        end

        // Interlock release window, counted in ticks
        ilock_next = q.ilock_cnt + 16'h0001;
        if (status_in.ilock_release) begin // see (R6)
            d.ilock_run = 1'b1;
            d.ilock_cnt = 16'h0000;
        end else if (q.ilock_run && q.tick) begin
            d.ilock_cnt = ilock_next;
            if (ilock_next >= q.ilock_time) begin
                d.ilock_run = 1'b0;
            end
        end

        // Power/alarm lamp, highest priority first
        d.lamps.pa_g = 1'b1; // see (R1)
        d.lamps.pa_r = 1'b0;
        if (!status_in.power) begin
            d.lamps.pa_g = 1'b0;
            d.lamps.pa_r = 1'b0;
        end else if (status_in.sim_mode) begin // see (R22)
            d.lamps.pa_g = (q.sim == SIM_GREEN) || (q.sim == SIM_BOTH);
            d.lamps.pa_r = (q.sim == SIM_RED) || (q.sim == SIM_BOTH);
        end else if (status_in.alarm) begin // see (R2)
            d.lamps.pa_g = 1'b0;
            d.lamps.pa_r = pattern_on;
        end else if (status_in.pwr_removal) begin // see (R3)
            d.lamps.pa_g = q.blink;
            d.lamps.pa_r = 1'b0;
        end else if (status_in.origin_func) begin // see (R7)
            d.lamps.pa_g = 1'b1;
            d.lamps.pa_r = 1'b1;
        end else if (q.ilock_run) begin // see (R6)
            d.lamps.pa_g = q.blink;
            d.lamps.pa_r = q.blink;
        end else if (status_in.info || status_in.teaching) begin // see (R4) see (R5)
            d.lamps.pa_g = pattern_on;
            d.lamps.pa_r = pattern_on;
        end

        // Module-state lamp
        d.lamps.ms_g = 1'b1; // see (R11)
        d.lamps.ms_r = 1'b0;
        if (!status_in.power) begin // see (R9)
            d.lamps.ms_g = 1'b0;
            d.lamps.ms_r = 1'b0;
        end else if (status_in.selftest) begin // see (R14)
            d.lamps.ms_g = q.blink;
            d.lamps.ms_r = ~q.blink;
        end else if (status_in.alarm_fatal) begin // see (R13)
            d.lamps.ms_g = 1'b0;
            d.lamps.ms_r = 1'b1;
        end else if (status_in.alarm || status_in.addr_dup) begin // see (R12)
            d.lamps.ms_g = 1'b0;
            d.lamps.ms_r = q.blink;
        end else if (status_in.comm_invalid) begin // see (R10)
            d.lamps.ms_g = q.blink;
            d.lamps.ms_r = 1'b0;
        end

        // Network-state lamp
        d.lamps.ns_g = 1'b0;
        d.lamps.ns_r = 1'b0;
        if (!status_in.power) begin // see (R9)
            d.lamps.ns_g = 1'b0;
        end else if (status_in.selftest) begin // see (R14)
            d.lamps.ns_g = q.blink;
            d.lamps.ns_r = ~q.blink;
        end else if (status_in.addr_dup) begin // see (R19)
            d.lamps.ns_r = 1'b1;
        end else if (status_in.conn_timeout) begin // see (R18)
            d.lamps.ns_r = q.blink;
        end else if (!status_in.online) begin // see (R15)
            d.lamps.ns_g = 1'b0;
        end else if (status_in.connected) begin // see (R17)
            d.lamps.ns_g = 1'b1;
        end else begin
            d.lamps.ns_g = q.blink; // see (R16)
        end

        // Link/activity lamp
        if (!status_in.power || !status_in.online) begin // see (R20)
            d.lamps.link = 1'b0;
        end else if (status_in.frame_activity) begin
            d.lamps.link = q.blink;
        end else begin
            d.lamps.link = 1'b1;
        end

        // Read data stands only in the cycle after the strobe
        d.rd_data = '0;
        if (rd_en_in) begin
            case (addr_in)
                ADDR_PRESCALE: d.rd_data = {16'h0000, q.prescale};
                ADDR_BLINK:    d.rd_data = {16'h0000, q.blink_off, q.blink_on};
                ADDR_ILOCK:    d.rd_data = {16'h0000, q.ilock_time};
                ADDR_STATUS:   d.rd_data = {21'h000000, q.lamps, q.ilock_run,
                                            q.blink, q.sim};
                default:       d.rd_data = '0;
            endcase
        end
    end

    // State register; every field has a constant reset value
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            q.prescale   <= PRESCALE_RST;
            q.blink_on   <= BLINK_ON_RST;
            q.blink_off  <= BLINK_OFF_RST;
            q.ilock_time <= ILOCK_TIME_RST;
            q.presc_cnt  <= 16'h0000;
            q.tick       <= 1'b0;
            q.phase_cnt  <= 8'h00;
            q.blink      <= 1'b0;
            q.grp        <= 5'h00;
            q.sim        <= SIM_GREEN;
            q.ilock_cnt  <= 16'h0000;
            q.ilock_run  <= 1'b0;
            q.lamps      <= '0;
            q.rd_data    <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from the state register
    assign lamps_out   = q.lamps;
    assign rd_data_out = q.rd_data;

    // Checks on the lamp decisions
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_dark_unpowered: assert property ( // see (R9)
        !status_in.power |=> !lamps_out.ms_g && !lamps_out.ms_r
                             && !lamps_out.ns_g && !lamps_out.ns_r)
        else $error("lamp lit without power");

    a_idle_steady_green: assert property ( // see (R1)
        status_in.power && !status_in.sim_mode && !status_in.alarm
        && !status_in.pwr_removal && !status_in.origin_func && !q.ilock_run
        && !status_in.info && !status_in.teaching
        |=> lamps_out.pa_g && !lamps_out.pa_r)
        else $error("idle power lamp not steady green");

    a_alarm_green_off: assert property ( // see (R2)
        status_in.power && !status_in.sim_mode && status_in.alarm
        |=> !lamps_out.pa_g)
        else $error("green lit during alarm");

    a_removal_red_off: assert property ( // see (R3)
        status_in.power && !status_in.sim_mode && !status_in.alarm
        && status_in.pwr_removal |=> !lamps_out.pa_r && (lamps_out.pa_g == $past(q.blink)))
        else $error("power removal lamp wrong");

    a_origin_both_lit: assert property ( // see (R7)
        status_in.power && !status_in.sim_mode && !status_in.alarm
        && !status_in.pwr_removal && status_in.origin_func
        |=> lamps_out.pa_g && lamps_out.pa_r)
        else $error("origin function lamp not both lit");

    a_fatal_steady_red: assert property ( // see (R13)
        status_in.power && !status_in.selftest && status_in.alarm_fatal
        |=> lamps_out.ms_r && !lamps_out.ms_g)
        else $error("fatal alarm not steady red");

    a_dup_steady_red: assert property ( // see (R19)
        status_in.power && !status_in.selftest && status_in.addr_dup
        |=> lamps_out.ns_r && !lamps_out.ns_g)
        else $error("address clash not steady red");

    a_connected_green: assert property ( // see (R17)
        status_in.power && !status_in.selftest && !status_in.addr_dup
        && !status_in.conn_timeout && status_in.online && status_in.connected
        |=> lamps_out.ns_g && !lamps_out.ns_r)
        else $error("connected lamp not steady green");

    a_link_quiet_on: assert property ( // see (R20)
        status_in.power && status_in.online && !status_in.frame_activity
        |=> lamps_out.link)
        else $error("link lamp off while online and quiet");

    a_tick_single: assert property ( // see (R21)
        q.tick |=> !q.tick)
        else $error("tick longer than one cycle");

    a_ilock_window: assert property ( // see (R6)
        status_in.ilock_release |=> q.ilock_run ##0 (q.ilock_cnt == 16'h0000))
        else $error("interlock window not started");

    a_alarm_red_phase: assert property ( // see (R2)
        status_in.power && !status_in.sim_mode && status_in.alarm
        |=> !lamps_out.pa_r || $past(q.blink))
        else $error("alarm red lit outside blink phase");

    a_info_both_pair: assert property ( // see (R4) see (R5)
        status_in.power && !status_in.sim_mode && !status_in.alarm
        && !status_in.pwr_removal && !status_in.origin_func && !q.ilock_run
        && (status_in.info || status_in.teaching)
        |=> lamps_out.pa_g == lamps_out.pa_r)
        else $error("double blink elements not together");

    a_ilock_both_blink: assert property ( // see (R6)
        status_in.power && !status_in.sim_mode && !status_in.alarm
        && !status_in.pwr_removal && !status_in.origin_func && q.ilock_run
        |=> (lamps_out.pa_g == $past(q.blink)) && (lamps_out.pa_r == $past(q.blink)))
        else $error("interlock lamp not blinking both");

    a_sim_phase_holds: assert property ( // see (R8)
        !half_end |=> $stable(q.sim))
        else $error("simulation phase moved mid half");

    a_sim_phase_wraps: assert property ( // see (R8)
        half_end && (q.sim == SIM_DARK) |=> q.sim == SIM_GREEN)
        else $error("simulation sequence did not wrap");

    a_comm_green_blink: assert property ( // see (R10)
        status_in.power && !status_in.selftest && !status_in.alarm_fatal
        && !status_in.alarm && !status_in.addr_dup && status_in.comm_invalid
        |=> !lamps_out.ms_r && (lamps_out.ms_g == $past(q.blink)))
        else $error("invalid settings lamp wrong");

    a_normal_ms_green: assert property ( // see (R11)
        status_in.power && !status_in.selftest && !status_in.alarm_fatal
        && !status_in.alarm && !status_in.addr_dup && !status_in.comm_invalid
        |=> lamps_out.ms_g && !lamps_out.ms_r)
        else $error("module lamp not steady green");

    a_selftest_alternate: assert property ( // see (R14)
        status_in.power && status_in.selftest
        |=> (lamps_out.ms_g != lamps_out.ms_r) && (lamps_out.ns_g != lamps_out.ns_r))
        else $error("self-test lamps not alternating");

    a_offline_ns_dark: assert property ( // see (R15)
        status_in.power && !status_in.selftest && !status_in.addr_dup
        && !status_in.conn_timeout && !status_in.online
        |=> !lamps_out.ns_g && !lamps_out.ns_r)
        else $error("network lamp lit while offline");

    a_timeout_red_blink: assert property ( // see (R18)
        status_in.power && !status_in.selftest && !status_in.addr_dup
        && status_in.conn_timeout
        |=> !lamps_out.ns_g && (lamps_out.ns_r == $past(q.blink)))
        else $error("timeout lamp not blinking red");

    a_link_offline_dark: assert property ( // see (R20)
        !status_in.online |=> !lamps_out.link)
        else $error("link lamp lit while offline");

endmodule : status_led_indicator_logic

//--- status_led_pkg.sv
// Purpose: Shared constants and carrier types for the front-panel lamp logic
// Assumes: 50 MHz system clock; blink timing runs from a 1 ms tick
// Notes:   Register byte offsets sit on 32-bit word boundaries
package status_led_pkg;

    // Clock and tick timing
    localparam int CLK_PERIOD_NS  = 20;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_CYCLES_MIN  = 2;
    localparam int TICK_CYCLES_MAX  = 65535;

    // Blink half-periods and interlock release time, in milliseconds
    localparam int BLINK_ON_MS    = 250;
    localparam int BLINK_OFF_MS   = 250;
    localparam int ILOCK_TIME_MS  = 1000;
    localparam logic [7:0] BLINK_ON_RST =
        8'(BLINK_ON_MS * (1000000 / TICK_PERIOD_NS));
    localparam logic [7:0] BLINK_OFF_RST =
        8'(BLINK_OFF_MS * (1000000 / TICK_PERIOD_NS));
    localparam logic [15:0] ILOCK_TIME_RST =
        16'(ILOCK_TIME_MS * (1000000 / TICK_PERIOD_NS));

    // Register map
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] ADDR_PRESCALE = 4'h0;
    localparam logic [3:0] ADDR_BLINK    = 4'h4;
    localparam logic [3:0] ADDR_ILOCK    = 4'h8;
    localparam logic [3:0] ADDR_STATUS   = 4'hc;
    localparam int BLINK_ON_LSB  = 0;
    localparam int BLINK_OFF_LSB = 8;

    // Blink group shaping
    localparam logic [4:0] INFO_BLINKS = 5'h02;
    localparam logic [4:0] GROUP_GAP   = 5'h02;
    localparam logic [4:0] MIN_BLINKS  = 5'h01;

    // Simulation mode colour sequence
    typedef enum logic [1:0] {
        SIM_GREEN = 2'b00,
        SIM_RED   = 2'b01,
        SIM_BOTH  = 2'b10,
        SIM_DARK  = 2'b11
    } sim_phase_t;

    // Status flags from the rest of the driver
    typedef struct packed {
        logic       power;
        logic       alarm;
        logic       alarm_fatal;
        logic [3:0] alarm_count;
        logic       pwr_removal;
        logic       info;
        logic       teaching;
        logic       ilock_release;
        logic       origin_func;
        logic       sim_mode;
        logic       selftest;
        logic       comm_invalid;
        logic       addr_dup;
        logic       online;
        logic       connected;
        logic       conn_timeout;
        logic       frame_activity;
    } status_t;

    // Lamp drive, one bit per element
    typedef struct packed {
        logic pa_g;
        logic pa_r;
        logic ms_g;
        logic ms_r;
        logic ns_g;
        logic ns_r;
        logic link;
    } lamps_t;

    // Whole state of the lamp block
    typedef struct packed {
        logic [15:0]       prescale;
        logic [7:0]        blink_on;
        logic [7:0]        blink_off;
        logic [15:0]       ilock_time;
        logic [15:0]       presc_cnt;
        logic              tick;
        logic [7:0]        phase_cnt;
        logic              blink;
        logic [4:0]        grp;
        sim_phase_t        sim;
        logic [15:0]       ilock_cnt;
        logic              ilock_run;
        lamps_t            lamps;
        logic [DATA_W-1:0] rd_data;
    } state_t;

endpackage : status_led_pkg

//--- status_led_panel_model.sv
// Purpose: Operator view of the front panel: counts lit cycles and turn-ons
// Assumes: Lamps are registered on sys_clk_in; one sample per rising edge
// Notes:   Clear restarts both counts so each observation window stands alone
`timescale 1ns/1ps

module status_led_panel_model
    import status_led_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        clear_in,
    input  wire lamps_t      lamps_in,
    output logic [6:0][7:0]  lit_out,
    output logic [6:0][7:0]  rises_out
);
    logic [6:0] prev_q;

    // An eye sees a blink as a turn-on; a steady lamp never turns on again
    always_ff @(posedge sys_clk_in) begin
        prev_q <= lamps_in;
        for (int i = 0; i < 7; i++) begin
            if (clear_in) begin
                lit_out[i]   <= 8'h00;
                rises_out[i] <= 8'h00;
            end else begin
                if (lamps_in[i]) begin
                    lit_out[i] <= lit_out[i] + 8'h01;
                end
                if (lamps_in[i] && !prev_q[i]) begin
                    rises_out[i] <= rises_out[i] + 8'h01;
                end
            end
        end
    end
endmodule : status_led_panel_model

//--- status_led_indicator_logic_tb.sv
// Purpose: Self-checking bench for the front-panel lamp logic
// Assumes: Prescale 2 and 2+2 tick blink halves keep blink periods short
// Notes:   Lamp classes: 0 dark, 1 steady, 2 blinking over a window
`timescale 1ns/1ps

module status_led_indicator_logic_tb;
    import status_led_pkg::*;
    localparam logic [1:0] D = 2'h0;
    localparam logic [1:0] S = 2'h1;
    localparam logic [1:0] B = 2'h2;
    localparam int         LIMIT = 8000;

    logic              sys_clk_in = 1'b0;
    logic              reset_n_in = 1'b0;
    status_t           status_in  = '0;
    logic [ADDR_W-1:0] addr_in    = 4'h0;
    logic [DATA_W-1:0] wr_data_in = 32'h0;
    logic              wr_en_in   = 1'b0;
    logic              rd_en_in   = 1'b0;
    lamps_t            lamps_out;
    logic [DATA_W-1:0] rd_data_out;
    logic              clear      = 1'b1;
    logic [6:0][7:0]   lit;
    logic [6:0][7:0]   rises;
    int                bad_count  = 0;
    int                n_checks   = 0;
    int                cycles     = 0;
    status_t           s;
    logic [DATA_W-1:0] rd;

    always #10 sys_clk_in = ~sys_clk_in;

    status_led_indicator_logic #(.TICK_CYCLES(2)) dut (
        .sys_clk_in (sys_clk_in), .reset_n_in (reset_n_in), .status_in (status_in),
        .addr_in (addr_in), .wr_data_in (wr_data_in), .wr_en_in (wr_en_in),
        .rd_en_in (rd_en_in), .lamps_out (lamps_out), .rd_data_out (rd_data_out));

    status_led_panel_model panel (
        .sys_clk_in (sys_clk_in), .clear_in (clear), .lamps_in (lamps_out),
        .lit_out (lit), .rises_out (rises));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // A hang is cut short here and still reaches the verdict
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic chk32(input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk32

    // Window judged per element; blink needs a turn-on and some dark time
    task automatic chk_lamps(input logic [13:0] exp, input int n);
        logic ok;
        for (int i = 0; i < 7; i++) begin
            case (exp[2*i +: 2])
                D:       ok = (lit[i] === 8'h00);
                S:       ok = (lit[i] === 8'(n)) && (rises[i] === 8'h00);
                default: ok = (rises[i] !== 8'h00) && (lit[i] < 8'(n));
            endcase
            n_checks++;
            if (ok !== 1'b1) begin
                bad_count++;
                $display("unexpected t=%0t lamp=%0d exp=%h got=%h", $time, i,
                         exp[2*i +: 2], {lit[i], rises[i]});
            end
        end
    endtask : chk_lamps

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr_in    <= a;
        wr_data_in <= d;
        wr_en_in   <= 1'b1;
        @(posedge sys_clk_in);
        wr_en_in   <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the read edge
    task automatic rdreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        addr_in  <= a;
        rd_en_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_en_in <= 1'b0;
        #1;
        d = rd_data_out;
    endtask : rdreg

    task automatic apply(input status_t st);
        @(posedge sys_clk_in);
        status_in <= st;
    endtask : apply

    task automatic observe(input logic [13:0] exp, input int n);
        @(posedge sys_clk_in);
        clear <= 1'b1;
        @(posedge sys_clk_in);
        clear <= 1'b0;
        repeat (n) @(posedge sys_clk_in);
        #1;
        chk_lamps(exp, n);
    endtask : observe

    // Settle covers the output register; window spans whole blink groups
    task automatic run_case(input status_t st, input logic [13:0] exp);
        apply(st);
        repeat (4) @(posedge sys_clk_in);
        observe(exp, 64);
    endtask : run_case

    task automatic t_registers();
        rdreg(ADDR_PRESCALE, rd);
        chk32(32'h2, rd);
        // Read data must fall back to zero one cycle later
        @(posedge sys_clk_in);
        #1;
        chk32(32'h0, rd_data_out);
        rdreg(ADDR_BLINK, rd);
        chk32({16'h0, BLINK_OFF_RST, BLINK_ON_RST}, rd);
        rdreg(ADDR_ILOCK, rd);
        chk32({16'h0, ILOCK_TIME_RST}, rd);
        rdreg(4'h2, rd);
        chk32(32'h0, rd);
        wr(ADDR_PRESCALE, 32'h1);
        rdreg(ADDR_PRESCALE, rd);
        chk32(32'h2, rd);
        wr(ADDR_BLINK, 32'h0202);
        wr(ADDR_ILOCK, 32'h000a);
        rdreg(ADDR_BLINK, rd);
        chk32(32'h0202, rd);
        rdreg(ADDR_ILOCK, rd);
        chk32(32'h000a, rd);
        $display("test registers done");
    endtask : t_registers

    task automatic t_power_lamp();
        s = '0;
        run_case(s, {D, D, D, D, D, D, D});
        s.power = 1'b1;
        run_case(s, {S, D, S, D, D, D, D});
        s.alarm = 1'b1;
        s.alarm_count = 4'h3;
        run_case(s, {D, B, D, B, D, D, D});
        s.pwr_removal = 1'b1;
        run_case(s, {D, B, D, B, D, D, D});
        s.alarm = 1'b0;
        run_case(s, {B, D, S, D, D, D, D});
        s.info = 1'b1;
        run_case(s, {B, D, S, D, D, D, D});
        s.pwr_removal = 1'b0;
        run_case(s, {B, B, S, D, D, D, D});
        s.origin_func = 1'b1;
        run_case(s, {S, S, S, D, D, D, D});
        // Status word: lamps in bits 10:4, window flag in bit 3, upper bits zero
        rdreg(ADDR_STATUS, rd);
        chk32(32'h0000_0700, rd & 32'hffff_fff8);
        s.origin_func = 1'b0;
        s.info = 1'b0;
        s.teaching = 1'b1;
        run_case(s, {B, B, S, D, D, D, D});
        s.teaching = 1'b0;
        s.sim_mode = 1'b1;
        s.alarm = 1'b1;
        run_case(s, {B, B, D, B, D, D, D});
        $display("test power lamp done");
    endtask : t_power_lamp

    task automatic t_interlock();
        s = '0;
        s.power = 1'b1;
        s.ilock_release = 1'b1;
        apply(s);
        s.ilock_release = 1'b0;
        apply(s);
        observe({B, B, S, D, D, D, D}, 14);
        repeat (16) @(posedge sys_clk_in);
        observe({S, D, S, D, D, D, D}, 64);
        $display("test interlock done");
    endtask : t_interlock

    task automatic t_module_net();
        s = '0;
        s.power = 1'b1;
        s.comm_invalid = 1'b1;
        run_case(s, {S, D, B, D, D, D, D});
        s.comm_invalid = 1'b0;
        s.alarm = 1'b1;
        s.alarm_fatal = 1'b1;
        run_case(s, {D, B, D, S, D, D, D});
        s = '0;
        s.power = 1'b1;
        s.selftest = 1'b1;
        run_case(s, {S, D, B, B, B, B, D});
        s.selftest = 1'b0;
        s.online = 1'b1;
        run_case(s, {S, D, S, D, B, D, S});
        s.connected = 1'b1;
        s.frame_activity = 1'b1;
        run_case(s, {S, D, S, D, S, D, B});
        s.connected = 1'b0;
        s.frame_activity = 1'b0;
        s.conn_timeout = 1'b1;
        run_case(s, {S, D, S, D, D, B, S});
        s = '0;
        s.power = 1'b1;
        s.addr_dup = 1'b1;
        run_case(s, {S, D, D, B, D, S, D});
        s.addr_dup = 1'b0;
        run_case(s, {S, D, S, D, D, D, D});
        $display("test module and network lamps done");
    endtask : t_module_net

    initial begin
        repeat (6) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        t_registers();
        t_power_lamp();
        t_interlock();
        t_module_net();
        complete_run();
    end
endmodule : status_led_indicator_logic_tb
